// >>> hw/rpsco_map.svh
// Constants for the receive parallel status and clock output block.
// Assumes inclusion by the package and the top module only.
`ifndef RPSCO_MAP_SVH
`define RPSCO_MAP_SVH
`define RPSCO_CHAR_W        10
`define RPSCO_STAT_W        3
`define RPSCO_COMMA_POS     7'h7c
`define RPSCO_COMMA_NEG     7'h03
`define RPSCO_COMMA_HI      9
`define RPSCO_COMMA_LO      3
`define RPSCO_SRC_RECOV     1'b0
`define RPSCO_SRC_REF       1'b1
`define RPSCO_RATE_FULL     1'b1
`define RPSCO_RATE_HALF     1'b0
`define RPSCO_STAT_RST      3'h0
`define RPSCO_STAT_COMMA    2
`define RPSCO_RAW_LOW_HI    1
`define RPSCO_RAW_LOW_LO    0
`define RPSCO_REF_HALF_RST  1'b0
`define RPSCO_DIV_RST       1'b0
`define RPSCO_HALF_RST      1'b0
`define RPSCO_CLK_P_RST     1'b0
`define RPSCO_CLK_N_RST     1'b1
`define RPSCO_RST_PULSE_NS  30
`define RPSCO_CLK_NS        40
`endif

// >>> hw/rpsco_pkg.sv
// Types for the receive parallel status and clock output block.
// Assumes the constants header sits beside it.
`include "rpsco_map.svh"
package rpsco_pkg;
  typedef struct packed {
    logic       decode_en;
    logic [2:0] decoded_status;
    logic [9:0] raw_char;
  } rpsco_char_t;
  typedef struct packed {
    logic source_sel;
    logic rate_sel;
    logic ref_half;
  } rpsco_cfg_t;
  typedef enum logic [1:0] {
    RPSCO_PH_LOW  = 2'b01,
    RPSCO_PH_HIGH = 2'b10
  } rpsco_phase_t;
endpackage

// >>> hw/rpsco_top.sv
// Receive status output register and interface clock generator for one channel.
// Assumes a character strobe from the receiver every system clock when present,
// and that the character and reference timing strobes are synchronous to CLK_SYS.
`timescale 1ns/10ps
`include "rpsco_map.svh"
module rpsco_top #(
  parameter int CHAR_W = `RPSCO_CHAR_W,
  parameter int STAT_W = `RPSCO_STAT_W
) (
  // Clock and reset.
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  // Timing strobes: recovered character tick and reference clock tick.
  input  wire logic                 RECOV_TICK,
  input  wire logic                 REF_TICK,
  // Configuration latches.
  input  wire rpsco_pkg::rpsco_cfg_t CFG_IN,
  input  wire logic                 CFG_LOAD,
  // Received character from the decoder.
  input  wire rpsco_pkg::rpsco_char_t CHAR_IN,
  // Outputs to the host.
  output logic [STAT_W-1:0]         RX_STATUS_OUT,
  output logic                      RX_IFACE_CLK_P,
  output logic                      RX_IFACE_CLK_N,
  output logic                      RX_IFACE_CLK_HALF
);

  rpsco_pkg::rpsco_cfg_t   cfg_q;
  rpsco_pkg::rpsco_phase_t phase_q;
  rpsco_pkg::rpsco_phase_t phase_d;
  logic                    tick;
  logic                    half_mode;
  logic                    div_q;
  logic                    edge_ok;
  logic [STAT_W-1:0]       stat_d;
  logic [STAT_W-1:0]       stat_q;
  logic                    comma;

  // latches reset
  // Configuration latches take their start values under reset.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cfg_q.source_sel <= `RPSCO_SRC_RECOV;
      cfg_q.rate_sel   <= `RPSCO_RATE_FULL;
      cfg_q.ref_half   <= `RPSCO_REF_HALF_RST;
    end
    else if (CFG_LOAD)
    begin
      cfg_q <= CFG_IN;
    end
  end

  // clock selection
  // The source latch picks which tick times the outputs.
  assign tick = (cfg_q.source_sel == `RPSCO_SRC_RECOV) ? RECOV_TICK : REF_TICK;

  // reference rate override
  // Rate latch selects half-rate dual-edge mode unless a half-rate reference with source latch one forces
  // the interface clock to follow the reference directly.
  always_comb
  begin
    if (cfg_q.ref_half && cfg_q.source_sel == `RPSCO_SRC_REF)
      half_mode = 1'b0;
    else
      half_mode = (cfg_q.rate_sel == `RPSCO_RATE_HALF);
  end

  // buffered or divided
  // The divider toggles once per character; the half-rate clock is this divided wave.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      div_q <= `RPSCO_DIV_RST;
    else if (tick)
      div_q <= ~div_q;
  end

  // Phase is high in the cycle after each tick, as the full-rate clock is.
  always_comb
  begin
    phase_d = rpsco_pkg::RPSCO_PH_LOW;
    case (phase_q)
      rpsco_pkg::RPSCO_PH_LOW:  if (tick) phase_d = rpsco_pkg::RPSCO_PH_HIGH;
      rpsco_pkg::RPSCO_PH_HIGH: if (tick) phase_d = rpsco_pkg::RPSCO_PH_HIGH;
      default:                  phase_d = rpsco_pkg::RPSCO_PH_LOW;
    endcase
  end

  // full rate clock
  // Full rate: one high system cycle per character gives a character-rate clock.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      phase_q <= rpsco_pkg::RPSCO_PH_LOW;
    else
      phase_q <= phase_d;
  end

  // half rate clock
  // Outputs: true and complement clocks from flip-flops.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      RX_IFACE_CLK_P <= `RPSCO_CLK_P_RST;
      RX_IFACE_CLK_N <= `RPSCO_CLK_N_RST;
    end
    else if (half_mode)
    begin
      RX_IFACE_CLK_P <= tick ? ~div_q : div_q;
      RX_IFACE_CLK_N <= tick ? div_q : ~div_q;
    end
    else
    begin
      RX_IFACE_CLK_P <= tick;
      RX_IFACE_CLK_N <= ~tick;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      RX_IFACE_CLK_HALF <= `RPSCO_HALF_RST;
    else
      RX_IFACE_CLK_HALF <= half_mode;
  end

  // comma flag
  // Comma detection on the seven-bit comma field of the raw character.
  assign comma = (CHAR_IN.raw_char[`RPSCO_COMMA_HI:`RPSCO_COMMA_LO] == `RPSCO_COMMA_POS)
              || (CHAR_IN.raw_char[`RPSCO_COMMA_HI:`RPSCO_COMMA_LO] == `RPSCO_COMMA_NEG);

  always_comb
  begin
    if (CHAR_IN.decode_en)
      stat_d = CHAR_IN.decoded_status;
    else
      stat_d = {comma, CHAR_IN.raw_char[`RPSCO_RAW_LOW_HI:`RPSCO_RAW_LOW_LO]};
  end

  // status both edges
  // Status loads with each tick, which is the rising edge at full rate and alternates
  // rising and falling edges of the divided clock at half rate.
  assign edge_ok = tick;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      stat_q <= `RPSCO_STAT_RST;
    else if (edge_ok)
      stat_q <= stat_d;
  end

  assign RX_STATUS_OUT = stat_q;

  a_status_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(tick) |-> $stable(RX_STATUS_OUT))
    else $error("status changed without a clock edge");

  a_cfg_load: assert property (@(posedge CLK_SYS) disable iff (RST)
    CFG_LOAD |=> (cfg_q == $past(CFG_IN)))
    else $error("configuration latch not loaded");

  a_cfg_keep: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CFG_LOAD |=> $stable(cfg_q))
    else $error("configuration latch changed without load");

  a_tick_recov: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.source_sel == `RPSCO_SRC_RECOV) |-> (tick == RECOV_TICK))
    else $error("recovered tick not selected");

  a_recov_pick: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.source_sel == `RPSCO_SRC_RECOV && !RECOV_TICK && !half_mode)
    |=> !RX_IFACE_CLK_P)
    else $error("unselected strobe reached the clock");

  a_tick_ref: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.source_sel == `RPSCO_SRC_REF) |-> (tick == REF_TICK))
    else $error("reference tick not selected");

  a_ref_pick: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.source_sel == `RPSCO_SRC_REF && !REF_TICK) |=> $stable(RX_STATUS_OUT))
    else $error("status moved without a reference tick");

  a_full_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!half_mode && tick) |=> (RX_IFACE_CLK_P && !RX_IFACE_CLK_N))
    else $error("full rate clock missing");

  a_full_low: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!half_mode && !tick) |=> (!RX_IFACE_CLK_P && RX_IFACE_CLK_N))
    else $error("full rate clock high without a tick");

  a_full_phase: assert property (@(posedge CLK_SYS) disable iff (RST)
    !half_mode |=> (RX_IFACE_CLK_P == (phase_q == rpsco_pkg::RPSCO_PH_HIGH)))
    else $error("full rate clock out of phase");

  a_half_toggle: assert property (@(posedge CLK_SYS) disable iff (RST)
    ($past(half_mode) && half_mode && tick && $past(tick) == 1'b0)
    |=> (RX_IFACE_CLK_P != $past(RX_IFACE_CLK_P)))
    else $error("half rate clock did not toggle");

  a_half_still: assert property (@(posedge CLK_SYS) disable iff (RST)
    (half_mode && $past(half_mode) && !tick) |=> $stable(RX_IFACE_CLK_P))
    else $error("half rate clock moved without a tick");

  a_div_track: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(half_mode) |-> (RX_IFACE_CLK_P == div_q))
    else $error("half rate clock differs from divider");

  a_bypass_low: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && !CHAR_IN.decode_en)
    |=> (RX_STATUS_OUT[`RPSCO_RAW_LOW_HI:`RPSCO_RAW_LOW_LO]
         == $past(CHAR_IN.raw_char[`RPSCO_RAW_LOW_HI:`RPSCO_RAW_LOW_LO])))
    else $error("bypass low bits wrong");

  a_bypass_comma: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && !CHAR_IN.decode_en) |=> (RX_STATUS_OUT[`RPSCO_STAT_COMMA] == $past(comma)))
    else $error("comma flag wrong");

  a_comma_pos: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && !CHAR_IN.decode_en
      && CHAR_IN.raw_char[`RPSCO_COMMA_HI:`RPSCO_COMMA_LO] == `RPSCO_COMMA_POS)
    |=> RX_STATUS_OUT[`RPSCO_STAT_COMMA])
    else $error("positive comma not flagged");

  a_comma_neg: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && !CHAR_IN.decode_en
      && CHAR_IN.raw_char[`RPSCO_COMMA_HI:`RPSCO_COMMA_LO] == `RPSCO_COMMA_NEG)
    |=> RX_STATUS_OUT[`RPSCO_STAT_COMMA])
    else $error("negative comma not flagged");

  a_decoded_out: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && CHAR_IN.decode_en) |=> (RX_STATUS_OUT == $past(CHAR_IN.decoded_status)))
    else $error("decoded status wrong");

  a_half_flag_on: assert property (@(posedge CLK_SYS) disable iff (RST)
    half_mode |=> RX_IFACE_CLK_HALF)
    else $error("half rate flag missing");

  a_half_flag_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    !half_mode |=> !RX_IFACE_CLK_HALF)
    else $error("half rate flag stuck");

  a_full_ref: assert property (@(posedge CLK_SYS) disable iff (RST)
    !cfg_q.ref_half |-> (half_mode == (cfg_q.rate_sel == `RPSCO_RATE_HALF)))
    else $error("full rate reference ignores rate select");

  a_ref_override: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.ref_half && cfg_q.source_sel) |-> !half_mode)
    else $error("rate select not ignored");

  a_ref_follow: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.ref_half && cfg_q.source_sel == `RPSCO_SRC_REF && REF_TICK)
    |=> (RX_IFACE_CLK_P && !RX_IFACE_CLK_N))
    else $error("clock does not follow the reference");

  a_rate_kept: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.source_sel == `RPSCO_SRC_RECOV)
    |-> (half_mode == (cfg_q.rate_sel == `RPSCO_RATE_HALF)))
    else $error("rate select ignored");

  a_ref_rate: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cfg_q.ref_half && cfg_q.source_sel == `RPSCO_SRC_RECOV)
    |-> (half_mode == (cfg_q.rate_sel == `RPSCO_RATE_HALF)))
    else $error("half rate reference ignores rate select");

  a_clock_pair: assert property (@(posedge CLK_SYS) disable iff (RST)
    RX_IFACE_CLK_P != RX_IFACE_CLK_N)
    else $error("interface clocks not complementary");

endmodule

// >>> bench/rpsco_host_model.sv
// Host side model that watches the true interface clock of one channel.
// Assumes the clock output is registered on CLK_SYS, so it is sampled there.
`timescale 1ns/10ps
module rpsco_host_model (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Interface clock from the device.
  input  wire logic        clk_p,
  // Count of interface clock transitions seen.
  output logic [31:0]      edges
);
  logic last_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      last_q <= 1'b0;
      edges  <= 32'h0;
    end
    else
    begin
      last_q <= clk_p;
      if (clk_p != last_q) edges <= edges + 32'h1;
    end
  end
endmodule

// >>> bench/test_rx_parallel_status_clock_out.sv
// Self-checking testbench for the receive status and interface clock block.
// Assumes the design files compile first and the package is visible.
`timescale 1ns/10ps
module test_rx_parallel_status_clock_out;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  logic                  clk_sys = 1'b0, rst = 1'b1, recov_tick = 1'b0, ref_tick = 1'b0;
  logic                  cfg_load = 1'b0, clk_p, clk_n, clk_half, prev_p;
  rpsco_pkg::rpsco_cfg_t  cfg_in = '0, cur;
  rpsco_pkg::rpsco_char_t char_in = '0;
  logic [2:0]            status, exp_st;
  logic [31:0]           rng = 32'h48, edges, e0;
  int                    failures = 0, n_checks = 0, ticks;
  rpsco_top i_dut (.CLK_SYS(clk_sys), .RST(rst), .RECOV_TICK(recov_tick), .REF_TICK(ref_tick),
    .CFG_IN(cfg_in), .CFG_LOAD(cfg_load), .CHAR_IN(char_in), .RX_STATUS_OUT(status),
    .RX_IFACE_CLK_P(clk_p), .RX_IFACE_CLK_N(clk_n), .RX_IFACE_CLK_HALF(clk_half));
  rpsco_host_model i_host (.clk_sys(clk_sys), .rst(rst), .clk_p(clk_p), .edges(edges));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic half_of(input rpsco_pkg::rpsco_cfg_t c);
    return (c.ref_half && c.source_sel) ? 1'b0 : (c.rate_sel == 1'b0);
  endfunction
  function automatic logic [2:0] st_of(input rpsco_pkg::rpsco_char_t c);
    logic comma;
    comma = (c.raw_char[9:3] == 7'h7c) || (c.raw_char[9:3] == 7'h03);
    return c.decode_en ? c.decoded_status : {comma, c.raw_char[1:0]};
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_rst();
    `CHK("status", 3'h0, status)
    `CHK("clk_p", 1'b0, clk_p)
    `CHK("clk_n", 1'b1, clk_n)
    `CHK("half", 1'b0, clk_half)
    cur = 3'b010;
    exp_st = 3'h0;
    prev_p = 1'b0;
  endtask
  task automatic step(input logic tk, input logic oth, input logic ld, input logic [2:0] cf);
    rpsco_pkg::rpsco_char_t c;
    @(negedge clk_sys);
    c = 14'(xs());
    if (xs() & 32'h4) c.raw_char[9:3] = (xs() & 32'h8) ? 7'h7c : 7'h03;
    char_in = c;
    cfg_in = cf;
    cfg_load = ld;
    {recov_tick, ref_tick} = cur.source_sel ? {oth, tk} : {tk, oth};
    @(posedge clk_sys);
    #1;
    if (tk) exp_st = st_of(c);
    if (tk) ticks++;
    prev_p = prev_p ^ tk;
    if (c.decode_en && tk)
      `CHK("status dec", exp_st, status)
    else
      `CHK("status raw", exp_st, status)
    `CHK("comma", exp_st[2], status[2])
    `CHK("clk_n", ~clk_p, clk_n)
    `CHK("half", half_of(cur), clk_half)
    if (!half_of(cur))
      `CHK("clk_p full", tk, clk_p)
    else
      `CHK("clk_p half", prev_p, clk_p)
    if (ld) cur = cf;
  endtask
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(40 * 3000);
    failures++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk_rst();
    // Walk every source, rate and reference mode with random back to back ticks.
    for (int m = 0; m < 8; m++)
    begin
      step(1'b0, 1'b0, 1'b1, m[2:0]);
      step(1'b1, 1'b1, 1'b0, cur);
      ticks = 0;
      for (int k = 0; k < 40; k++)
      begin
        step(1'(xs()), 1'(xs() >> 1), 1'b0, cur);
        if (k == 0) e0 = edges;
      end
      step(1'b0, 1'b1, 1'b0, cur);
      if (half_of(cur)) `CHK("edges", ticks, edges - e0)
    end
    @(negedge clk_sys);
    rst = 1'b1;
    recov_tick = 1'b0;
    ref_tick = 1'b0;
    cfg_load = 1'b0;
    #1;
    chk_rst();
    @(negedge clk_sys);
    rst = 1'b0;
    for (int k = 0; k < 6; k++)
      step(1'b1, 1'b0, 1'b0, cur);
    test_done();
  end
endmodule
